// *** design/sfcp_core.v ***
/*
 * Instruction decoder, status byte and write protection of a small serial
 * flash. Runs on clk_sys_in; the serial pins are oversampled, so the clock
 * must be at least eight times the serial clock. Program and erase timing
 * live in the array controller outside, which takes one-cycle requests and
 * reports busy; array read data must be valid three cycles after the read
 * address changes.
 */
// Contract
// R1: write-enable latch clears at reset, latch-clear, program, erase, auto top address.
// R2: with latch clear, no program or erase request is issued.
// R3: protection bits select none, upper quarter, upper half or whole array.
// R4: status write changes protection bits only with pin high or lock clear.
// R5: full-array erase only when both protection bits are zero.
// R6: reset sets both protection bits and clears the lock bit.
// R7: pin low with lock set freezes lock and protection bits.
// R8: status bit shows auto-increment mode; single-byte mode after reset.
// R9: instruction starts at select fall; bits sampled on rising clock, msb first.
// R10: every bus cycle is eight serial clock periods.
// R11: host sends latch-set before any program or erase.
// R12: host raises select after the last bit; device acts then.
// R13: select rising inside a bus cycle aborts the instruction.
// R14: status write works only directly after the unlock instruction.
// R15: auto program starts with address and data, then opcode plus data only.
// R16: status read repeats the status byte until select rises.
// R17: id read gives maker code for address bit 0 low, else part code.
// R18: address bits above bit 16 are ignored.
// R19: fast read skips one dummy byte, ignoring its value.
// R20: status byte layout: busy, latch, protection bits, auto, lock.
// R21: array read streams consecutive addresses, wrapping at the top.
// R22: program or erase into a protected region is ignored.
// R23: latch-set sets the write-enable latch when select rises.
// R24: unknown opcodes do nothing.
`timescale 1ns/100ps
`include "sfcp_defs.vh"

module sfcp_core #(
    parameter [7:0] MAKER_CODE = 8'h5a,   // arbitrary value
    parameter [7:0] PART_CODE  = 8'h3c    // arbitrary value
) (
    input  wire                    clk_sys_in,         // system clock
    input  wire                    srst_in,            // synchronous reset, power-up
    input  wire                    sck_in,             // serial clock pin
    input  wire                    sel_n_in,           // select pin, active low
    input  wire                    si_in,              // serial data in pin
    input  wire                    wp_n_in,            // write-protect pin, active low
    output reg                     so_out,             // serial data out
    output wire                    so_oe_out,          // so drive enable
    input  wire                    array_busy_in,      // array operation running
    input  wire [7:0]              array_rd_data_in,   // array byte at read address
    output wire [`SFCP_ADDR_W-1:0] array_rd_addr_out,  // array read address
    output reg                     prog_req_out,       // program one byte, pulse
    output reg                     sect_erase_req_out, // sector erase, pulse
    output reg                     blk_erase_req_out,  // block erase, pulse
    output reg                     chip_erase_req_out, // full erase, pulse
    output reg  [`SFCP_ADDR_W-1:0] op_addr_out,        // program or erase address
    output reg  [7:0]              op_data_out,        // program data
    output wire [7:0]              status_out          // status byte view
);

    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_OPC   = 7'h02;
    localparam [6:0] ST_ADDR  = 7'h04;
    localparam [6:0] ST_DUMMY = 7'h08;
    localparam [6:0] ST_DIN   = 7'h10;
    localparam [6:0] ST_DOUT  = 7'h20;
    localparam [6:0] ST_SKIP  = 7'h40;

    reg [2:0]              sck_s;
    reg [2:0]              sel_s;
    reg [1:0]              si_s;
    reg [1:0]              wp_s;
    reg [6:0]              state;
    reg [2:0]              bit_cnt;
    reg [1:0]              byte_idx;
    reg [7:0]              shift;
    reg [7:0]              opcode;
    reg [`SFCP_ADDR_W-1:0] addr;
    reg [`SFCP_ADDR_W-1:0] rd_addr;
    reg [`SFCP_ADDR_W-1:0] auto_addr;
    reg [7:0]              din;
    reg [7:0]              out_sh;
    reg                    ready;
    reg                    armed;
    reg                    write_enable_latch;
    reg [1:0]              protect;
    reg                    lock;
    reg                    auto_mode;

    wire                    sck_rise = sck_s[1] & ~sck_s[2];
    wire                    sck_fall = ~sck_s[1] & sck_s[2];
    wire                    sel_fall = ~sel_s[1] & sel_s[2];
    wire                    sel_rise = sel_s[1] & ~sel_s[2];
    wire                    active   = ~sel_s[1];
    wire [7:0]              in_byte  = {shift[6:0], si_s[1]};
    wire                    byte_end = sck_rise & (bit_cnt == `SFCP_BYTE_BITS);
    wire [`SFCP_ADDR_W-1:0] in_addr  = {addr[`SFCP_ADDR_W-2:0], si_s[1]};
    wire [`SFCP_ADDR_W-1:0] target   = auto_mode ? auto_addr : addr;
    wire                    may_write = write_enable_latch & ~array_busy_in;
    wire                    stat_ok  = wp_s[1] | ~lock;

    // upper quarter starts at 18000, upper half at 10000
    function prot_hit;
        input [1:0]              lvl;
        input [`SFCP_ADDR_W-1:0] a;
        begin
            prot_hit = (lvl == 2'h3) |
                       ((lvl == 2'h2) & a[16]) |
                       ((lvl == 2'h1) & a[16] & a[15]); // R3
        end
    endfunction

    assign status_out = {lock, auto_mode, 2'h0, protect, write_enable_latch, array_busy_in}; // R20 R8
    assign array_rd_addr_out = rd_addr;
    assign so_oe_out = active & (state == ST_DOUT);

    // pins cross in through two flops, three for sck and select; only the later stages feed logic
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            sck_s <= 3'h0;
            sel_s <= 3'h7;
            si_s  <= 2'h0;
            wp_s  <= 2'h3;
        end else begin
            sck_s <= {sck_s[1:0], sck_in};
            sel_s <= {sel_s[1:0], sel_n_in};
            si_s  <= {si_s[0], si_in};
            wp_s  <= {wp_s[0], wp_n_in};
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            state              <= ST_IDLE;
            bit_cnt            <= 3'h0;
            byte_idx           <= 2'h0;
            shift              <= 8'h00;
            opcode             <= 8'h00;
            addr               <= {`SFCP_ADDR_W{1'b0}};
            rd_addr            <= {`SFCP_ADDR_W{1'b0}};
            auto_addr          <= {`SFCP_ADDR_W{1'b0}};
            din                <= 8'h00;
            out_sh             <= 8'h00;
            so_out             <= 1'b0;
            ready              <= 1'b0;
            armed              <= 1'b0;
            write_enable_latch <= `SFCP_RST_WR_EN;   // R1
            protect            <= `SFCP_RST_PROTECT; // R6
            lock               <= `SFCP_RST_LOCK;    // R6
            auto_mode          <= `SFCP_RST_AUTO;    // R8
            prog_req_out       <= 1'b0;
            sect_erase_req_out <= 1'b0;
            blk_erase_req_out  <= 1'b0;
            chip_erase_req_out <= 1'b0;
            op_addr_out        <= {`SFCP_ADDR_W{1'b0}};
            op_data_out        <= 8'h00;
        end else begin
            prog_req_out       <= 1'b0;
            sect_erase_req_out <= 1'b0;
            blk_erase_req_out  <= 1'b0;
            chip_erase_req_out <= 1'b0;
            if (sel_fall) begin
                state   <= ST_OPC; // R9
                bit_cnt <= 3'h0;
                ready   <= 1'b0;
            end else if (sel_rise) begin
                state   <= ST_IDLE;
                bit_cnt <= 3'h0;
                // unlock lives for exactly one following instruction
                armed   <= ready & (bit_cnt == 3'h0) & (opcode == `SFCP_OP_STAT_UNLOCK); // R14
                if (ready && bit_cnt == 3'h0) begin // R12 R13
                    case (opcode)
                        `SFCP_OP_LATCH_SET: write_enable_latch <= 1'b1; // R23
                        `SFCP_OP_LATCH_CLR: begin
                            write_enable_latch <= 1'b0; // R1
                            auto_mode          <= 1'b0;
                        end
                        `SFCP_OP_STAT_WRITE: begin
                            if (armed && stat_ok) begin // R14 R4 R7
                                protect <= din[`SFCP_ST_PL_HIGH:`SFCP_ST_PL_LOW];
                                lock    <= din[`SFCP_ST_LOCK];
                            end
                        end
                        `SFCP_OP_BYTE_PROG: begin
                            if (may_write && !prot_hit(protect, addr)) begin // R2 R22
                                prog_req_out <= 1'b1;
                                op_addr_out  <= addr;
                                op_data_out  <= din;
                                write_enable_latch <= 1'b0; // R1
                            end
                        end
                        `SFCP_OP_AUTO_PROG: begin
                            if (may_write && !prot_hit(protect, target)) begin // R2 R22 R15
                                prog_req_out <= 1'b1;
                                op_addr_out  <= target;
                                op_data_out  <= din;
                                auto_addr    <= target + 1'b1;
                                auto_mode    <= 1'b1; // R8
                                // no wrap: leave auto mode at the top address
                                if (target == `SFCP_ADDR_TOP) begin
                                    auto_mode          <= 1'b0; // R1
                                    write_enable_latch <= 1'b0; // R1
                                end
                            end
                        end
                        `SFCP_OP_SECT_ERASE: begin
                            if (may_write && !prot_hit(protect, addr)) begin // R2 R22
                                sect_erase_req_out <= 1'b1;
                                op_addr_out        <= addr;
                                write_enable_latch <= 1'b0; // R1
                            end
                        end
                        `SFCP_OP_BLK_ERASE_A, `SFCP_OP_BLK_ERASE_B: begin
                            if (may_write && !prot_hit(protect, addr)) begin // R2 R22
                                blk_erase_req_out <= 1'b1;
                                op_addr_out       <= addr;
                                write_enable_latch <= 1'b0; // R1
                            end
                        end
                        `SFCP_OP_CHIP_ERA_A, `SFCP_OP_CHIP_ERA_B: begin
                            if (may_write && protect == 2'h0) begin // R2 R5
                                chip_erase_req_out <= 1'b1;
                                op_addr_out        <= {`SFCP_ADDR_W{1'b0}};
                                write_enable_latch <= 1'b0; // R1
                            end
                        end
                        default: ; // R24
                    endcase
                end
            end else if (active) begin
                if (sck_rise && state != ST_IDLE) begin
                    shift   <= in_byte; // R9
                    bit_cnt <= bit_cnt + 1'b1; // R10
                    if (state == ST_ADDR)
                        addr <= in_addr; // R18
                end
                if (byte_end) begin
                    case (state)
                        ST_OPC: begin
                            opcode   <= in_byte;
                            byte_idx <= 2'h0;
                            case (in_byte)
                                `SFCP_OP_READ, `SFCP_OP_FAST_READ, `SFCP_OP_BYTE_PROG,
                                `SFCP_OP_SECT_ERASE, `SFCP_OP_BLK_ERASE_A, `SFCP_OP_BLK_ERASE_B,
                                `SFCP_OP_ID_READ_A, `SFCP_OP_ID_READ_B:
                                    state <= ST_ADDR;
                                `SFCP_OP_AUTO_PROG:
                                    state <= auto_mode ? ST_DIN : ST_ADDR; // R15
                                `SFCP_OP_STAT_READ:
                                    state <= ST_DOUT; // R16
                                `SFCP_OP_STAT_WRITE:
                                    state <= ST_DIN;
                                `SFCP_OP_LATCH_SET, `SFCP_OP_LATCH_CLR, `SFCP_OP_STAT_UNLOCK,
                                `SFCP_OP_CHIP_ERA_A, `SFCP_OP_CHIP_ERA_B: begin
                                    ready <= 1'b1;
                                    state <= ST_SKIP;
                                end
                                default:
                                    state <= ST_SKIP; // R24
                            endcase
                        end
                        ST_ADDR: begin
                            byte_idx <= byte_idx + 1'b1;
                            if (byte_idx == `SFCP_ADDR_BYTES) begin
                                rd_addr <= in_addr;
                                case (opcode)
                                    `SFCP_OP_READ, `SFCP_OP_ID_READ_A, `SFCP_OP_ID_READ_B:
                                        state <= ST_DOUT;
                                    `SFCP_OP_FAST_READ:
                                        state <= ST_DUMMY; // R19
                                    `SFCP_OP_BYTE_PROG, `SFCP_OP_AUTO_PROG:
                                        state <= ST_DIN;
                                    default: begin
                                        ready <= 1'b1;
                                        state <= ST_SKIP;
                                    end
                                endcase
                            end
                        end
                        ST_DUMMY: state <= ST_DOUT; // R19
                        ST_DIN: begin
                            din   <= in_byte;
                            ready <= 1'b1;
                            state <= ST_SKIP;
                        end
                        default: ;
                    endcase
                end
                // reload at each byte boundary; the same byte repeats for status and id
                if (sck_fall && state == ST_DOUT) begin
                    if (bit_cnt == 3'h0) begin
                        case (opcode)
                            `SFCP_OP_STAT_READ: begin
                                out_sh <= {status_out[6:0], 1'b0}; // R16
                                so_out <= status_out[7];
                            end
                            `SFCP_OP_ID_READ_A, `SFCP_OP_ID_READ_B: begin
                                out_sh <= rd_addr[0] ? {PART_CODE[6:0], 1'b0} : {MAKER_CODE[6:0], 1'b0}; // R17
                                so_out <= rd_addr[0] ? PART_CODE[7] : MAKER_CODE[7]; // R17
                            end
                            default: begin
                                out_sh  <= {array_rd_data_in[6:0], 1'b0};
                                so_out  <= array_rd_data_in[7];
                                rd_addr <= rd_addr + 1'b1; // R21
                            end
                        endcase
                    end else begin
                        so_out <= out_sh[7];
                        out_sh <= {out_sh[6:0], 1'b0};
                    end
                end
            end
        end
    end

endmodule // sfcp_core

// *** include/sfcp_defs.vh ***
/*
 * Constants of the serial flash command and protection block: opcodes,
 * status byte layout, reset values and array geometry.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef SFCP_DEFS_VH
`define SFCP_DEFS_VH

// opcodes
`define SFCP_OP_READ        8'h03
`define SFCP_OP_FAST_READ   8'h0b
`define SFCP_OP_SECT_ERASE  8'h20
`define SFCP_OP_BLK_ERASE_A 8'h52
`define SFCP_OP_BLK_ERASE_B 8'hd8
`define SFCP_OP_CHIP_ERA_A  8'h60
`define SFCP_OP_CHIP_ERA_B  8'hc7
`define SFCP_OP_BYTE_PROG   8'h02
`define SFCP_OP_AUTO_PROG   8'haf
`define SFCP_OP_STAT_READ   8'h05
`define SFCP_OP_STAT_UNLOCK 8'h50
`define SFCP_OP_STAT_WRITE  8'h01
`define SFCP_OP_LATCH_SET   8'h06
`define SFCP_OP_LATCH_CLR   8'h04
`define SFCP_OP_ID_READ_A   8'h90
`define SFCP_OP_ID_READ_B   8'hab

// status byte bit positions
`define SFCP_ST_BUSY        0
`define SFCP_ST_WR_EN       1
`define SFCP_ST_PL_LOW      2
`define SFCP_ST_PL_HIGH     3
`define SFCP_ST_AUTO        6
`define SFCP_ST_LOCK        7

// reset values
`define SFCP_RST_PROTECT    2'h3
`define SFCP_RST_LOCK       1'h0
`define SFCP_RST_WR_EN      1'h0
`define SFCP_RST_AUTO       1'h0

// geometry: address bit 16 is the highest array bit
`define SFCP_ADDR_W         17
`define SFCP_ADDR_TOP       17'h1ffff
`define SFCP_BYTE_BITS      3'h7
`define SFCP_ADDR_BYTES     2'h2

`endif

// *** testbench/sfcp_props.sv ***
/* port assertions for sfcp_core: status layout, write gating, protection.
   assumes the bind in the bench top file and one clock domain. */
`timescale 1ns/100ps
module sfcp_props (
    input wire        clk_sys_in,         // system clock
    input wire        srst_in,            // sync reset
    input wire        sel_n_in,           // select pin
    input wire        wp_n_in,            // write-protect pin
    input wire        array_busy_in,      // array busy
    input wire        so_oe_out,          // so drive enable
    input wire        prog_req_out,       // program pulse
    input wire        sect_erase_req_out, // sector erase pulse
    input wire        blk_erase_req_out,  // block erase pulse
    input wire        chip_erase_req_out, // chip erase pulse
    input wire [16:0] op_addr_out,        // target address
    input wire [7:0]  status_out          // status byte
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    wire       any_wr = prog_req_out | sect_erase_req_out | blk_erase_req_out;
    wire [1:0] lvl    = status_out[3:2];
    sequence s_locked; (status_out[7] && !wp_n_in) [*4]; endsequence
    sequence s_erase; sect_erase_req_out || blk_erase_req_out || chip_erase_req_out; endsequence
    a_reset_status: assert property ($fell(srst_in) |-> status_out[7:1] == 7'h06)
        else $error("status wrong after reset");
    a_busy_bit: assert property (status_out[0] == array_busy_in)
        else $error("busy bit differs from busy input");
    a_resv_zero: assert property (status_out[5:4] == 2'h0)
        else $error("reserved status bits set");
    a_latch_gate: assert property ((any_wr || chip_erase_req_out) |-> $past(status_out[1]))
        else $error("request without write enable");
    a_chip_unprot: assert property (chip_erase_req_out |-> $past(lvl) == 2'h0)
        else $error("chip erase while protected");
    a_region_guard: assert property (any_wr |-> $past(lvl) == 2'h0 ||
        ($past(lvl) == 2'h1 && op_addr_out < 17'h18000) || ($past(lvl) == 2'h2 && op_addr_out < 17'h10000))
        else $error("request into protected region");
    a_erase_latch: assert property (s_erase |-> ##[0:2] !status_out[1])
        else $error("write enable kept after erase");
    a_lock_frozen: assert property (s_locked |=> $stable({status_out[7], lvl}))
        else $error("locked protection bits changed");
    a_oe_select: assert property (so_oe_out |-> !$past(sel_n_in, 5))
        else $error("so driven after select release");
endmodule // sfcp_props

// *** testbench/sfcp_host.sv ***
/* serial host model: mode 0 or mode 3 frames, eight system clocks per serial bit.
   assumes a 20 MHz system clock, giving a 400 ns serial clock. */
`timescale 1ns/100ps
module sfcp_host (
    input  wire  clk_sys_in, // system clock
    input  wire  so_in,      // device serial out
    output logic sck_out,    // serial clock
    output logic sel_n_out,  // select, active low
    output logic si_out      // serial data to device
);
    logic idle_hi = 1'b0; // sck level between frames: high means mode 3
    initial begin
        sck_out = 1'b0;
        sel_n_out = 1'b1;
        si_out = 1'b0;
    end
    // nb bits sent msb first; so sampled at every rise
    task automatic frame(input int nb, input logic [63:0] d, output logic [63:0] rx);
        int i;
        rx = '0;
        // clock settles to its idle level while still deselected
        @(posedge clk_sys_in) sck_out <= idle_hi;
        @(posedge clk_sys_in) sel_n_out <= 1'b0;
        for (i = nb - 1; i >= 0; i--) begin
            sck_out <= 1'b0;
            si_out <= d[i];
            repeat (4) @(posedge clk_sys_in);
            sck_out <= 1'b1;
            rx = {rx[62:0], so_in};
            repeat (4) @(posedge clk_sys_in);
        end
        sck_out <= idle_hi;
        repeat (4) @(posedge clk_sys_in);
        sel_n_out <= 1'b1;
        si_out <= ~si_out;
        repeat (8) @(posedge clk_sys_in);
    endtask
endmodule // sfcp_host

// *** testbench/test_serial_flash_command_protect.sv ***
/* bench for sfcp_core: host model on the pins, array read model, request scoreboard.
   assumes sfcp_props.sv and sfcp_host.sv are compiled first. */
`timescale 1ns/100ps
module test_serial_flash_command_protect;
    localparam logic [7:0] MAKER = 8'ha5; // arbitrary value
    localparam logic [7:0] PART  = 8'h1e; // arbitrary value
    logic        clk_sys_in = 0, srst_in = 1, wp_n_in = 1, array_busy_in = 0;
    logic [7:0]  array_rd_data_in = 0;
    wire         sck, sel_n, si, so_out, so_oe_out, prog_req_out, sect_erase_req_out, blk_erase_req_out;
    wire         chip_erase_req_out;
    wire [16:0]  array_rd_addr_out, op_addr_out;
    wire [7:0]   op_data_out, status_out;
    integer      errors = 0, n_checks = 0, cycles = 0, seed = 32'h513f, l;
    logic [28:0] exp_q[$];
    logic [63:0] rx;
    logic [16:0] hi [4] = '{17'h1ffff, 17'h18000, 17'h10000, 17'h00000};
    logic [7:0]  d;
    always #25 clk_sys_in = ~clk_sys_in;
    sfcp_core #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .sck_in(sck), .sel_n_in(sel_n), .si_in(si), .wp_n_in(wp_n_in), .so_out(so_out), .so_oe_out(so_oe_out),
        .array_busy_in(array_busy_in), .array_rd_data_in(array_rd_data_in), .array_rd_addr_out(array_rd_addr_out),
        .prog_req_out(prog_req_out), .sect_erase_req_out(sect_erase_req_out), .blk_erase_req_out(blk_erase_req_out),
        .chip_erase_req_out(chip_erase_req_out), .op_addr_out(op_addr_out), .op_data_out(op_data_out),
        .status_out(status_out));
    // released so reads as the inverse, so data outside the drive window fails
    sfcp_host host (.clk_sys_in(clk_sys_in), .so_in(so_oe_out ? so_out : ~so_out), .sck_out(sck),
        .sel_n_out(sel_n), .si_out(si));
    function automatic logic [7:0] rd_f(input logic [16:0] a);
        return a[7:0] ^ a[16:9] ^ 8'h5a;
    endfunction
    always @(posedge clk_sys_in) array_rd_data_in <= rd_f(array_rd_addr_out);
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // request monitor: oldest note against each pulse
    always @(posedge clk_sys_in) begin
        if (prog_req_out | sect_erase_req_out | blk_erase_req_out | chip_erase_req_out) begin
            if (exp_q.size() == 0)
                chk(1, 0);
            else
                chk({prog_req_out, sect_erase_req_out, blk_erase_req_out, chip_erase_req_out, op_addr_out,
                     prog_req_out ? op_data_out : 8'h00}, exp_q.pop_front());
        end
    end
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            $display("ERROR at %0t: timeout", $time);
            wrap_up();
        end
    end
    task automatic cmd(input int nb, input logic [63:0] v);
        host.frame(nb * 8, v, rx);
    endtask
    task automatic st(input logic [7:0] e);
        cmd(3, 24'h050000);
        chk(rx[15:0], {e, e});
    endtask
    task automatic wsr(input logic [7:0] v);
        cmd(1, 8'h50);
        cmd(2, {8'h01, v});
    endtask
    // upper address bits always hold 55, so they must be dropped
    task automatic wr(input logic [7:0] op, input logic [16:0] a, input int nb, input logic [3:0] k,
                      input logic ok, input logic wen);
        logic [7:0] dat;
        dat = $random(seed);
        if (wen) cmd(1, 8'h06);
        if (ok) exp_q.push_back({k, k == 4'h1 ? 17'h0 : a, k[3] ? dat : 8'h00});
        cmd(nb, {op, 7'h55, a, dat} >> (8 * (5 - nb)));
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        st(8'h0c);
        wr(8'h02, 17'h00010, 5, 4'h8, 0, 0);
        cmd(1, 8'h06);
        st(8'h0e);
        wr(8'h02, 17'h00010, 5, 4'h8, 0, 0);
        cmd(1, 8'h04);
        st(8'h0c);
        host.frame(11, {8'h06, 3'h0}, rx);
        st(8'h0c);
        cmd(2, 16'h0100);
        cmd(1, 8'h50);
        cmd(1, 8'hff);
        cmd(2, 16'h0100);
        st(8'h0c);
        $display("latch and abort test done");
        for (l = 3; l >= 0; l--) begin
            wsr({4'h0, l[1:0], 2'h0});
            st({4'h0, l[1:0], 2'h0});
            wr(8'h02, hi[l], 5, 4'h8, l == 0, 1);
            wr(8'h02, hi[l] - 17'h1, 5, 4'h8, l != 3, 1);
            wr(l[0] ? 8'h60 : 8'hc7, 17'h0, 1, 4'h1, l == 0, 1);
            cmd(1, 8'h04);
        end
        wr(8'h20, 17'h03000, 4, 4'h4, 1, 1);
        wr(8'h52, 17'h08000, 4, 4'h2, 1, 1);
        wr(8'hd8, 17'h18000, 4, 4'h2, 1, 1);
        st(8'h00);
        $display("protection test done");
        wr(8'haf, 17'h1fffe, 5, 4'h8, 1, 1);
        st(8'h42);
        d = $random(seed);
        exp_q.push_back({4'h8, 17'h1ffff, d});
        cmd(2, {8'haf, d});
        st(8'h00);
        wr(8'haf, 17'h00100, 5, 4'h8, 1, 1);
        cmd(1, 8'h04);
        st(8'h00);
        $display("auto program test done");
        cmd(7, {8'h03, 7'h55, 17'h1ffff, 24'h0});
        chk(rx[23:0], {rd_f(17'h1ffff), rd_f(17'h0), rd_f(17'h1)});
        cmd(7, {8'h0b, 7'h00, 17'h00abc, 8'($random(seed)), 16'h0});
        chk(rx[15:0], {rd_f(17'h00abc), rd_f(17'h00abd)});
        host.idle_hi = 1'b1;
        for (l = 0; l < 4; l++) begin
            cmd(6, {l[1] ? 8'hab : 8'h90, 16'h0, 7'h0, l[0], 16'h0});
            chk(rx[15:0], {2{l[0] ? PART : MAKER}});
        end
        host.idle_hi = 1'b0;
        $display("read test done");
        wsr(8'h8c);
        st(8'h8c);
        wp_n_in <= 1'b0;
        wsr(8'h00);
        st(8'h8c);
        wp_n_in <= 1'b1;
        wsr(8'h00);
        st(8'h00);
        array_busy_in <= 1'b1;
        st(8'h01);
        array_busy_in <= 1'b0;
        chk(exp_q.size(), 0);
        $display("lock test done");
        wrap_up();
    end
endmodule // test_serial_flash_command_protect
bind sfcp_core sfcp_props u_props (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .sel_n_in(sel_n_in),
    .wp_n_in(wp_n_in), .array_busy_in(array_busy_in), .so_oe_out(so_oe_out), .prog_req_out(prog_req_out),
    .sect_erase_req_out(sect_erase_req_out), .blk_erase_req_out(blk_erase_req_out),
    .chip_erase_req_out(chip_erase_req_out), .op_addr_out(op_addr_out), .status_out(status_out));
